// [rtl/esp_pkg.sv]
package esp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_LINES  = 8;
  localparam int N_PERIPH = 11;
  localparam int N_SRC    = 19;
  localparam int SRC_W    = 5;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_SENSE    = 10'h0F4;
  localparam logic [9:0] IDX_ENABLE   = 10'h0F5;
  localparam logic [9:0] IDX_PEND     = 10'h0F6;
  localparam logic [9:0] IDX_PRIO_A   = 10'h0F8;
  localparam logic [9:0] IDX_PRIO_B   = 10'h0F9;
  localparam logic [9:0] IDX_EVT_STAT = 10'h0FA;
  localparam logic [9:0] IDX_EVT_MASK = 10'h0FB;

  localparam logic [ADDR_W-1:0] ADR_SENSE    = {IDX_SENSE, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_ENABLE   = {IDX_ENABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_PEND     = {IDX_PEND, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_PRIO_A   = {IDX_PRIO_A, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_PRIO_B   = {IDX_PRIO_B, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_EVT_STAT = {IDX_EVT_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_EVT_MASK = {IDX_EVT_MASK, 2'h0};

  // ----------------------------------------------------------------
  // reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SENSE   = 8'h00;
  localparam logic [7:0] RST_ENABLE  = 8'h00;
  localparam logic [7:0] RST_PRIO    = 8'h00;
  localparam logic [7:0] RST_PEND    = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_PINS    = 8'hFF;
  localparam logic [7:0] PRIO_B_BITS = 8'hFE;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // source ids: 0..7 are the pin lines, then peripheral lines
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_WDT  = 5'h08;
  localparam logic [SRC_W-1:0] SRC_RFSH = 5'h09;
  localparam logic [SRC_W-1:0] SRC_TMR1 = 5'h0A;
  localparam logic [SRC_W-1:0] SRC_TMR2 = 5'h0B;
  localparam logic [SRC_W-1:0] SRC_TMR3 = 5'h0C;
  localparam logic [SRC_W-1:0] SRC_TMR4 = 5'h0D;
  localparam logic [SRC_W-1:0] SRC_DMA0 = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_DMA1 = 5'h0F;
  localparam logic [SRC_W-1:0] SRC_SER0 = 5'h10;
  localparam logic [SRC_W-1:0] SRC_SER1 = 5'h11;
  localparam logic [SRC_W-1:0] SRC_ADC  = 5'h12;

  // priority bit positions
  localparam int PA_LINE0 = 7;
  localparam int PA_LINE1 = 6;
  localparam int PA_L23   = 5;
  localparam int PA_L47   = 4;
  localparam int PA_WDT   = 3;
  localparam int PA_TMR1  = 1;
  localparam int PA_TMR2  = 0;
  localparam int PB_TMR3  = 7;
  localparam int PB_TMR4  = 6;
  localparam int PB_DMA0  = 5;
  localparam int PB_DMA1  = 4;
  localparam int PB_SER0  = 3;
  localparam int PB_SER1  = 2;
  localparam int PB_ADC   = 1;

  // priority level of one source from the two priority registers
  function automatic logic esp_src_level(input logic [SRC_W-1:0] src,
                                         input logic [7:0] pa,
                                         input logic [7:0] pb);
    logic lv;
    lv = 1'b0;
    case (src)
      5'h00: lv = pa[PA_LINE0];
      5'h01: lv = pa[PA_LINE1];
      5'h02, 5'h03: lv = pa[PA_L23];
      5'h04, 5'h05, 5'h06, 5'h07: lv = pa[PA_L47];
      SRC_WDT, SRC_RFSH: lv = pa[PA_WDT];
      SRC_TMR1: lv = pa[PA_TMR1];
      SRC_TMR2: lv = pa[PA_TMR2];
      SRC_TMR3: lv = pb[PB_TMR3];
      SRC_TMR4: lv = pb[PB_TMR4];
      SRC_DMA0: lv = pb[PB_DMA0];
      SRC_DMA1: lv = pb[PB_DMA1];
      SRC_SER0: lv = pb[PB_SER0];
      SRC_SER1: lv = pb[PB_SER1];
      SRC_ADC:  lv = pb[PB_ADC];
      default:  lv = 1'b0;
    endcase
    return lv;
  endfunction : esp_src_level

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } esp_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } esp_axi_rsp_t;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
    logic             level;
  } esp_cpu_req_t;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
  } esp_exc_t;

  typedef struct packed {
    logic [7:0]        sense;
    logic [7:0]        enable;
    logic [7:0]        prio_a;
    logic [7:0]        prio_b;
    logic [7:0]        pend;
    logic [7:0]        armed;
    logic [7:0]        pin_prev;
    logic [7:0]        evt_stat;
    logic [7:0]        evt_mask;
    logic              aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic              w_v;
    logic [DATA_W-1:0] w_d;
    logic [3:0]        w_s;
    logic              b_v;
    logic [1:0]        b_r;
    logic              r_v;
    logic [DATA_W-1:0] r_d;
    logic [1:0]        r_r;
    logic              cpu_v;
    logic [SRC_W-1:0]  cpu_src;
    logic              cpu_lvl;
    logic              irq;
  } esp_state_t;

  localparam esp_state_t ST_RST = '{sense: RST_SENSE, enable: RST_ENABLE,
                                    prio_a: RST_PRIO, prio_b: RST_PRIO,
                                    pend: RST_PEND, pin_prev: RST_PINS,
                                    evt_mask: RST_MASK, default: '0};

endpackage : esp_pkg

// [rtl/esp_prio_select.sv]
`timescale 1ns/10ps
module esp_prio_select (
  input  wire logic [esp_pkg::N_SRC-1:0] elig,
  input  wire logic [esp_pkg::N_SRC-1:0] level,
  output logic                           found,
  output logic [esp_pkg::SRC_W-1:0]      src,
  output logic                           lvl
);

  logic [esp_pkg::N_SRC-1:0] hi_vec;
  logic [esp_pkg::N_SRC-1:0] pick_vec;

  // per-source high-level qualification
  genvar g;
  generate
    for (g = 0; g < esp_pkg::N_SRC; g++)
    begin : g_hi
      assign hi_vec[g] = elig[g] & level[g];
    end
  endgenerate

  // any level-1 source shuts out all level-0 ones
  assign pick_vec = (|hi_vec) ? hi_vec : elig;

  // fixed order: the lowest id wins inside the chosen level
  always_comb
  begin
    found = |pick_vec;
    lvl   = |hi_vec;
    src   = '0;
    for (int i = esp_pkg::N_SRC - 1; i >= 0; i--)
    begin
      if (pick_vec[i])
      begin
        src = i[esp_pkg::SRC_W-1:0];
      end
    end
  end

endmodule : esp_prio_select

// [rtl/esp_irq_ctrl.sv]
`timescale 1ns/10ps

module esp_irq_ctrl (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire esp_pkg::esp_axi_req_t             axi_req,
  output esp_pkg::esp_axi_rsp_t                  axi_rsp,
  input  wire logic [esp_pkg::N_LINES-1:0]       ext_req_n,
  input  wire logic [esp_pkg::N_PERIPH-1:0]      periph_req,
  input  wire esp_pkg::esp_exc_t                 exc_done,
  output esp_pkg::esp_cpu_req_t                  cpu_req,
  output logic                                   irq
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  esp_pkg::esp_state_t st_q;
  esp_pkg::esp_state_t st_d;

  logic [7:0]                    lvl_hit;
  logic [7:0]                    edge_hit;
  logic [7:0]                    set_vec;
  logic [7:0]                    ack_vec;
  logic [7:0]                    clr_ack;
  logic [7:0]                    clr_sw;
  logic [7:0]                    elig_ext;
  logic [esp_pkg::N_SRC-1:0]     elig;
  logic [esp_pkg::N_SRC-1:0]     lvl_vec;
  logic                          sel_found;
  logic [esp_pkg::SRC_W-1:0]     sel_src;
  logic                          sel_lvl;
  logic                          wr_fire;
  logic                          ar_hs;
  logic                          hi_any;

  // ----------------------------------------------------------------
  // pin sensing
  // ----------------------------------------------------------------
  // low level or high-to-low step, chosen per line
  assign lvl_hit  = ~st_q.sense & ~ext_req_n;
  assign edge_hit = st_q.sense & st_q.pin_prev & ~ext_req_n;
  assign set_vec  = lvl_hit | edge_hit;

  // exception-handling clears; level lines need the pin back high
  genvar g;
  generate
    for (g = 0; g < esp_pkg::N_LINES; g++)
    begin : g_ack
      assign ack_vec[g] = exc_done.valid && (exc_done.src == esp_pkg::SRC_W'(g));
    end
  endgenerate
  assign clr_ack = ack_vec & ((~st_q.sense & ext_req_n) | st_q.sense);

  // software clear: only armed bits written with 0, ones are ignored
  assign wr_fire = st_q.aw_v && st_q.w_v && !st_q.b_v;
  assign clr_sw  = (wr_fire && st_q.aw_a == esp_pkg::ADR_PEND && st_q.w_s[0])
                   ? (st_q.armed & ~st_q.w_d[7:0]) : 8'h00;

  // ----------------------------------------------------------------
  // request selection
  // ----------------------------------------------------------------
  // pin lines reach the cpu only with flag and enable both set
  assign elig_ext = st_q.pend & st_q.enable;
  assign elig     = {periph_req, elig_ext};

  // level of every source from the priority registers
  generate
    for (g = 0; g < esp_pkg::N_SRC; g++)
    begin : g_lvl
      assign lvl_vec[g] = esp_pkg::esp_src_level(esp_pkg::SRC_W'(g),
                                                 st_q.prio_a, st_q.prio_b);
    end
  endgenerate
  assign hi_any = |(elig & lvl_vec);

  esp_prio_select u_sel (
    .elig  (elig),
    .level (lvl_vec),
    .found (sel_found),
    .src   (sel_src),
    .lvl   (sel_lvl)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign ar_hs = axi_req.arvalid && !st_q.r_v;

  // one process for registers, flags, bus and request
  always_comb
  begin
    st_d          = st_q;
    st_d.pin_prev = ext_req_n;

    // set wins over any clear in the same cycle
    st_d.pend     = (st_q.pend & ~(clr_sw | clr_ack)) | set_vec;
    st_d.evt_stat = st_q.evt_stat | (set_vec & ~st_q.pend);

    // write address and data are taken in either order
    if (axi_req.awvalid && !st_q.aw_v && !st_q.b_v)
    begin
      st_d.aw_v = 1'b1;
      st_d.aw_a = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_q.w_v && !st_q.b_v)
    begin
      st_d.w_v = 1'b1;
      st_d.w_d = axi_req.wdata;
      st_d.w_s = axi_req.wstrb;
    end

    // register write once both halves are held
    if (wr_fire)
    begin
      st_d.aw_v = 1'b0;
      st_d.w_v  = 1'b0;
      st_d.b_v  = 1'b1;
      st_d.b_r  = esp_pkg::RESP_OKAY;
      case (st_q.aw_a)
        esp_pkg::ADR_SENSE:
          if (st_q.w_s[0]) st_d.sense = st_q.w_d[7:0];
        esp_pkg::ADR_ENABLE:
          if (st_q.w_s[0]) st_d.enable = st_q.w_d[7:0];
        esp_pkg::ADR_PEND:
          st_d.armed = 8'h00;
        esp_pkg::ADR_PRIO_A:
          if (st_q.w_s[0]) st_d.prio_a = st_q.w_d[7:0];
        esp_pkg::ADR_PRIO_B:
          if (st_q.w_s[0]) st_d.prio_b = st_q.w_d[7:0] & esp_pkg::PRIO_B_BITS;
        esp_pkg::ADR_EVT_STAT:
          if (st_q.w_s[0])
            st_d.evt_stat = (st_q.evt_stat & ~st_q.w_d[7:0]) | (set_vec & ~st_q.pend);
        esp_pkg::ADR_EVT_MASK:
          if (st_q.w_s[0]) st_d.evt_mask = st_q.w_d[7:0];
        default:
          st_d.b_r = esp_pkg::RESP_SLVERR;
      endcase
    end
    if (st_q.b_v && axi_req.bready)
    begin
      st_d.b_v = 1'b0;
    end

    // read data captured at the address handshake
    if (ar_hs)
    begin
      st_d.r_v = 1'b1;
      st_d.r_r = esp_pkg::RESP_OKAY;
      st_d.r_d = '0;
      case (axi_req.araddr)
        esp_pkg::ADR_SENSE:    st_d.r_d[7:0] = st_q.sense;
        esp_pkg::ADR_ENABLE:   st_d.r_d[7:0] = st_q.enable;
        esp_pkg::ADR_PEND:
        begin
          st_d.r_d[7:0] = st_q.pend;
          st_d.armed    = st_q.armed | st_q.pend;
        end
        esp_pkg::ADR_PRIO_A:   st_d.r_d[7:0] = st_q.prio_a;
        esp_pkg::ADR_PRIO_B:   st_d.r_d[7:0] = st_q.prio_b;
        esp_pkg::ADR_EVT_STAT: st_d.r_d[7:0] = st_q.evt_stat;
        esp_pkg::ADR_EVT_MASK: st_d.r_d[7:0] = st_q.evt_mask;
        default:               st_d.r_r = esp_pkg::RESP_SLVERR;
      endcase
    end
    else if (st_q.r_v && axi_req.rready)
    begin
      st_d.r_v = 1'b0;
    end

    // a flag cleared by handling must be read again before a 0 write
    st_d.armed   = st_d.armed & st_d.pend;

    // request to the cpu, one cycle behind the flags
    st_d.cpu_v   = sel_found;
    st_d.cpu_src = sel_src;
    st_d.cpu_lvl = sel_lvl;
    st_d.irq     = |(st_d.evt_stat & st_d.evt_mask);
  end

  // synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= esp_pkg::ST_RST;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // handshakes combinational, data from flops
  assign axi_rsp.awready = !st_q.aw_v && !st_q.b_v;
  assign axi_rsp.wready  = !st_q.w_v && !st_q.b_v;
  assign axi_rsp.bvalid  = st_q.b_v;
  assign axi_rsp.bresp   = st_q.b_r;
  assign axi_rsp.arready = !st_q.r_v;
  assign axi_rsp.rvalid  = st_q.r_v;
  assign axi_rsp.rdata   = st_q.r_d;
  assign axi_rsp.rresp   = st_q.r_r;
  assign cpu_req.valid   = st_q.cpu_v;
  assign cpu_req.src     = st_q.cpu_src;
  assign cpu_req.level   = st_q.cpu_lvl;
  assign irq             = st_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pend_read;
    ar_hs && axi_req.araddr == esp_pkg::ADR_PEND && st_q.pend != 8'h00;
  endsequence

  sequence s_arm_held;
    ##1 ((st_q.armed & $past(st_q.pend) & st_q.pend) == ($past(st_q.pend) & st_q.pend));
  endsequence

  a_level_sets_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lvl_hit != 8'h00 |=> ((st_q.pend & $past(lvl_hit)) == $past(lvl_hit)))
    else $error("low level pin did not set its flag");

  a_edge_sets_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    edge_hit != 8'h00 |=> ((st_q.pend & $past(edge_hit)) == $past(edge_hit)))
    else $error("falling edge did not set its flag");

  a_flag_rise_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((st_q.pend & ~$past(st_q.pend) & ~$past(set_vec)) == 8'h00))
    else $error("pending flag rose without a pin event");

  a_flag_fall_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((~st_q.pend & $past(st_q.pend) & ~$past(clr_sw) & ~$past(clr_ack)) == 8'h00))
    else $error("pending flag cleared without read-then-write or handling");

  a_read_arms_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_pend_read |-> s_arm_held)
    else $error("read of set flags did not arm the clear");

  a_edge_ack_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ack_vec & st_q.sense & ~set_vec) != 8'h00
    |=> ((st_q.pend & $past(ack_vec) & $past(st_q.sense) & ~$past(set_vec)) == 8'h00))
    else $error("edge flag not cleared by handling");

  a_level_ack_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ack_vec & ~st_q.sense & ext_req_n) != 8'h00
    |=> ((st_q.pend & $past(ack_vec) & ~$past(st_q.sense) & $past(ext_req_n)) == 8'h00))
    else $error("level flag not cleared by handling with pin high");

  a_enable_gates_req: assert property (
    @(posedge aclk) disable iff (!aresetn)
    elig_ext == 8'h00 |=> !(st_q.cpu_v && st_q.cpu_src < esp_pkg::SRC_WDT))
    else $error("pin line requested without flag and enable");

  a_high_first: assert property (
    @(posedge aclk) disable iff (!aresetn)
    hi_any |=> st_q.cpu_v && st_q.cpu_lvl ##1 1'b1)
    else $error("level 0 request chosen over a level 1 request");

  a_line0_top: assert property (
    @(posedge aclk) disable iff (!aresetn)
    elig[0] && st_q.prio_a[esp_pkg::PA_LINE0] |=> st_q.cpu_v && st_q.cpu_src == 5'h00)
    else $error("line 0 at level 1 not chosen first");

  a_level_map: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sel_found |-> sel_lvl == esp_pkg::esp_src_level(sel_src, st_q.prio_a, st_q.prio_b))
    else $error("chosen level disagrees with priority registers");

  a_resp_held: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.b_v && !axi_req.bready |=> st_q.b_v && $stable(st_q.b_r))
    else $error("write response dropped before bready");

  // ----------------------------------------------------------------
  // bus, reset, register and interrupt checks
  // ----------------------------------------------------------------
  // the write answer comes one edge after both halves are held
  sequence s_wr_both;
    st_q.aw_v && st_q.w_v && !st_q.b_v;
  endsequence

  sequence s_wr_answer;
    ##1 (st_q.b_v && !st_q.aw_v && !st_q.w_v);
  endsequence

  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_both |-> s_wr_answer)
    else $error("write response missing after both halves");

  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hs |=> st_q.r_v)
    else $error("read data not offered after address");

  a_read_held: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.r_v && !axi_req.rready |=> st_q.r_v && $stable(st_q.r_d))
    else $error("read data dropped before rready");

  a_reset_quiet: assert property (
    @(posedge aclk)
    !aresetn |=> !st_q.b_v && !st_q.r_v && !st_q.cpu_v && !st_q.irq)
    else $error("outputs not idle after reset");

  a_prio_b_rsvd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.prio_b[0] == 1'b0)
    else $error("reserved priority bit became set");

  a_write_disarms: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && st_q.aw_a == esp_pkg::ADR_PEND && !ar_hs |=> st_q.armed == 8'h00)
    else $error("pending write left flags armed");

  a_pend_read_data: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hs && axi_req.araddr == esp_pkg::ADR_PEND |=> st_q.r_d[7:0] == $past(st_q.pend))
    else $error("pending read returned wrong flags");

  a_irq_mask_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_q.evt_mask == 8'h00 |-> !st_q.irq)
    else $error("interrupt raised with every event masked");

endmodule : esp_irq_ctrl

// [testbench/esp_src_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// request sources in front of the block
// ----------------------------------------------------------------
module esp_src_model (
  input  wire logic        aclk,
  input  wire logic [7:0]  pin_low,
  input  wire logic [10:0] per_on,
  output logic [7:0]       ext_req_n,
  output logic [10:0]      periph_req
);
  // pins idle high as behind a pull-up; changes land just after an edge
  always @(posedge aclk)
  begin
    ext_req_n  <= ~pin_low;
    periph_req <= per_on;
  end
endmodule : esp_src_model

// [testbench/ext_irq_sense_priority_tb.sv]
`timescale 1ns/10ps
module ext_irq_sense_priority_tb;
  logic                  aclk;
  logic                  aresetn;
  esp_pkg::esp_axi_req_t req;
  esp_pkg::esp_axi_rsp_t rsp;
  esp_pkg::esp_exc_t     exc;
  esp_pkg::esp_cpu_req_t cpu;
  logic                  irq;
  logic [7:0]            pin_low;
  logic [10:0]           per_on;
  logic [7:0]            ext_req_n;
  logic [10:0]           periph_req;
  logic [31:0]           rdat;
  logic [1:0]            rresp;
  logic [1:0]            bres;
  int                    err_count = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  esp_irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .ext_req_n(ext_req_n),
                    .periph_req(periph_req), .exc_done(exc), .cpu_req(cpu), .irq(irq));
  esp_src_model src (.aclk(aclk), .pin_low(pin_low), .per_on(per_on), .ext_req_n(ext_req_n),
                     .periph_req(periph_req));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    // no local limit: only the cycle guard ends a hung wait
    do
    begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    bres = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a, rdat, rresp);
    chk(rdat, exp);
  endtask : rdchk

  // one-cycle report of exception handling for a source
  task automatic exc_pulse(input logic [4:0] s);
    @(posedge aclk);
    exc.valid <= 1'b1;
    exc.src   <= s;
    @(posedge aclk);
    exc.valid <= 1'b0;
  endtask : exc_pulse

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    req = '0;
    exc = '0;
    pin_low = 8'h00;
    per_on = 11'h000;
    aresetn = 1'b0;
    wt(10);
    aresetn <= 1'b1;
    // reset values and reserved bit
    rdchk(esp_pkg::ADR_SENSE, 32'h0);
    rdchk(esp_pkg::ADR_ENABLE, 32'h0);
    rdchk(esp_pkg::ADR_PRIO_A, 32'h0);
    rdchk(esp_pkg::ADR_PEND, 32'h0);
    wr(esp_pkg::ADR_PRIO_B, 32'hFF);
    chk({30'h0, bres}, 32'h0);
    rdchk(esp_pkg::ADR_PRIO_B, 32'hFE);
    wr(esp_pkg::ADR_PRIO_B, 32'h00);
    rd(12'h004, rdat, rresp);
    chk({30'h0, rresp}, 32'h2);
    chk(rdat, 32'h0);
    wr(12'h004, 32'hFF);
    chk({30'h0, bres}, 32'h2);
    // level line 0: request, refused set, clear only after a read
    wr(esp_pkg::ADR_ENABLE, 32'h01);
    pin_low <= 8'h01;
    wt(5);
    rdchk(esp_pkg::ADR_PEND, 32'h01);
    chk({25'h0, cpu}, 32'h40);
    pin_low <= 8'h00;
    wt(2);
    wr(esp_pkg::ADR_PEND, 32'hFF);
    wr(esp_pkg::ADR_PEND, 32'h00);
    rdchk(esp_pkg::ADR_PEND, 32'h01);
    wr(esp_pkg::ADR_PEND, 32'h00);
    rdchk(esp_pkg::ADR_PEND, 32'h00);
    // level auto-clear needs the pin high at handling time
    pin_low <= 8'h01;
    wt(3);
    exc_pulse(5'h00);
    wt(2);
    rdchk(esp_pkg::ADR_PEND, 32'h01);
    pin_low <= 8'h00;
    wt(3);
    exc_pulse(5'h00);
    wt(3);
    rdchk(esp_pkg::ADR_PEND, 32'h00);
    chk({25'h0, cpu}, 32'h00);
    // edge line 1, disabled at first, pin held low over the clear
    wr(esp_pkg::ADR_SENSE, 32'h02);
    pin_low <= 8'h02;
    wt(4);
    rdchk(esp_pkg::ADR_PEND, 32'h02);
    chk({25'h0, cpu}, 32'h00);
    exc_pulse(5'h01);
    wt(3);
    rdchk(esp_pkg::ADR_PEND, 32'h00);
    pin_low <= 8'h00;
    wt(3);
    pin_low <= 8'h02;
    wr(esp_pkg::ADR_ENABLE, 32'h03);
    wt(3);
    chk({25'h0, cpu}, 32'h42);
    exc_pulse(5'h01);
    pin_low <= 8'h00;
    // priority: line 2 level against watchdog and converter
    wr(esp_pkg::ADR_ENABLE, 32'h07);
    pin_low <= 8'h04;
    per_on <= 11'h401;
    wt(4);
    chk({25'h0, cpu}, 32'h44);
    wr(esp_pkg::ADR_PRIO_A, 32'h08);
    wt(3);
    chk({25'h0, cpu}, 32'h51);
    wr(esp_pkg::ADR_PRIO_A, 32'h20);
    wt(3);
    chk({25'h0, cpu}, 32'h45);
    wr(esp_pkg::ADR_PRIO_A, 32'h00);
    wr(esp_pkg::ADR_PRIO_B, 32'h02);
    wt(3);
    chk({25'h0, cpu}, 32'h65);
    // line 0 at level 1 beats the converter at level 1
    pin_low <= 8'h05;
    wr(esp_pkg::ADR_PRIO_A, 32'h80);
    wt(3);
    chk({25'h0, cpu}, 32'h41);
    // event status, mask and the interrupt line
    rdchk(esp_pkg::ADR_EVT_STAT, 32'h07);
    chk({31'h0, irq}, 32'h0);
    wr(esp_pkg::ADR_EVT_MASK, 32'h04);
    wt(3);
    chk({31'h0, irq}, 32'h1);
    wr(esp_pkg::ADR_EVT_STAT, 32'h07);
    wt(3);
    chk({31'h0, irq}, 32'h0);
    rdchk(esp_pkg::ADR_EVT_STAT, 32'h00);
    // mid-run reset: defaults back, held low pins set their flags again
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
    rdchk(esp_pkg::ADR_ENABLE, 32'h0);
    rdchk(esp_pkg::ADR_PEND, 32'h05);
    rdchk(esp_pkg::ADR_PRIO_B, 32'h0);
    chk({25'h0, cpu}, 32'h50);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule : ext_irq_sense_priority_tb
